// file: core/sdc_pkg.sv
/*
  sdc_pkg: command encodings, field positions and widths shared by the
  synchronous dram command front end and its storage array.
  assumes nothing of its surroundings.
*/
package sdc_pkg;
  // ---------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------
  localparam int ADDR_W      = 12;
  localparam int COL_W       = 8;
  localparam int BANK_W      = 2;
  localparam int DATA_W      = 16;
  localparam int NBANK       = 4;
  localparam int READ_LAT    = 2;   // byte mask to hi-z latency on reads
  localparam int AP_BIT      = 10;  // all-banks / auto-precharge address bit
  localparam int MODE_W      = 12;
  localparam logic [MODE_W-1:0] MODE_RST = 12'h000;

  // ---------------------------------------------------------------
  // command codes {ras_n, cas_n, we_n}
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    SDC_MRS  = 3'b000,
    SDC_REF  = 3'b001,
    SDC_PRE  = 3'b010,
    SDC_ACT  = 3'b011,
    SDC_WR   = 3'b100,
    SDC_RD   = 3'b101,
    SDC_BST  = 3'b110,
    SDC_NOP  = 3'b111
  } sdc_cmd_t;

  typedef enum logic [1:0] {
    SDC_RUN     = 2'b00,
    SDC_PDOWN   = 2'b01,
    SDC_SUSPEND = 2'b10,
    SDC_SELFREF = 2'b11
  } sdc_pwr_t;
endpackage

// file: core/sdc_mem.sv
/*
  sdc_mem: byte-writable storage array with registered read data.
  assumes address and write strobes come from the core_clk domain.
*/
`timescale 1ns/1ps
module sdc_mem
  import sdc_pkg::*;
#(
  parameter int AW = 10
) (
  // clock
  input  wire logic              core_clk,
  // write side
  input  wire logic [AW-1:0]     wr_addr,
  input  wire logic [1:0]        wr_byte_en,
  input  wire logic [DATA_W-1:0] wr_data,
  // read side
  input  wire logic [AW-1:0]     rd_addr,
  output logic      [DATA_W-1:0] rd_data
);
  logic [DATA_W-1:0] mem [2**AW];

  // per-lane writes; no reset since array contents are undefined at power-up
  always_ff @(posedge core_clk) begin
    if (wr_byte_en[0]) begin
      mem[wr_addr][7:0] <= wr_data[7:0];
    end
    if (wr_byte_en[1]) begin
      mem[wr_addr][15:8] <= wr_data[15:8];
    end
  end

  // registered read
  always_ff @(posedge core_clk) begin
    rd_data <= mem[rd_addr];
  end
endmodule

// file: core/sdc_core.sv
/*
  sdc_core: command front end of a four-bank, 16-bit synchronous dram.
  pins are sampled through a two-stage synchroniser on core_clk; the
  far side is a controller that obeys init and bank timing.
*/
`timescale 1ns/1ps
module sdc_core
  import sdc_pkg::*;
#(
  parameter int BURST_LEN = 1
) (
  // clock and reset
  input  wire logic              core_clk,
  input  wire logic              rst_n,
  // command pins
  input  wire logic              clock_gate_enable,
  input  wire logic              chip_select_n,
  input  wire logic              ras_n,
  input  wire logic              cas_n,
  input  wire logic              we_n,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic              bank_select_lo,
  input  wire logic              bank_select_hi,
  input  wire logic              upper_byte_mask,
  input  wire logic              lower_byte_mask,
  // data pins
  input  wire logic [DATA_W-1:0] dq_in,
  output logic      [DATA_W-1:0] dq_out,
  output logic      [1:0]        dq_oe,
  // status
  output logic      [NBANK-1:0]  bank_open,
  output logic      [MODE_W-1:0] mode_value,
  output logic      [1:0]        power_state
);
  localparam int MAW = BANK_W + COL_W;

  // elaboration check: the beat counter is four bits wide
  if (BURST_LEN < 1 || BURST_LEN > 8) begin : g_bad_burst
    $error("burst length out of range");
  end

  // ---------------------------------------------------------------
  // pin synchroniser: first stage read only by the second
  // ---------------------------------------------------------------
  localparam int PW = 1 + 1 + 3 + ADDR_W + 2 + 2 + DATA_W;
  logic [PW-1:0] pin_s1_r, pin_s2_r;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_r <= '1;
      pin_s2_r <= '1;
    end else begin
      pin_s1_r <= {clock_gate_enable, chip_select_n, ras_n, cas_n, we_n, addr,
                   bank_select_hi, bank_select_lo, upper_byte_mask, lower_byte_mask, dq_in};
      pin_s2_r <= pin_s1_r;
    end
  end

  logic              cke_s, cs_n_s;
  logic [2:0]        strb_s;
  logic [ADDR_W-1:0] addr_s;
  logic [BANK_W-1:0] bank_s;
  logic [1:0]        mask_s;
  logic [DATA_W-1:0] dq_s;
  assign {cke_s, cs_n_s, strb_s, addr_s, bank_s, mask_s, dq_s} = pin_s2_r;

  // ---------------------------------------------------------------
  // command decode
  // ---------------------------------------------------------------
  // gate stalls the clock for the device, so commands need cke high twice
  logic cke_prev_r;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) cke_prev_r <= 1'b1;
    else        cke_prev_r <= cke_s;
  end

  sdc_cmd_t cmd;
  logic     live;
  assign live = cke_s && cke_prev_r && !cs_n_s;
  assign cmd  = live ? sdc_cmd_t'(strb_s) : SDC_NOP;

  // ---------------------------------------------------------------
  // mode register
  // ---------------------------------------------------------------
  logic [MODE_W-1:0] mode_r;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n)              mode_r <= MODE_RST;
    else if (cmd == SDC_MRS) mode_r <= addr_s;
  end
  assign mode_value = mode_r;

  // ---------------------------------------------------------------
  // bank state: open flags and open rows
  // ---------------------------------------------------------------
  logic [NBANK-1:0]  open_r;
  logic [ADDR_W-1:0] row_r [NBANK];
  logic              burst_ap_r;
  logic [BANK_W-1:0] burst_bank_r;
  logic [3:0]        burst_left_r;
  logic              burst_wr_r;
  logic [COL_W-1:0]  col_r;
  logic              burst_end;
  assign burst_end = (burst_left_r == 4'd1);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      open_r <= '0;
    end else begin
      if (burst_end && burst_ap_r) open_r[burst_bank_r] <= 1'b0;
      if (cmd == SDC_ACT) open_r[bank_s] <= 1'b1;
      if (cmd == SDC_PRE) begin
        if (addr_s[AP_BIT]) open_r <= '0;
        else                open_r[bank_s] <= 1'b0;
      end
    end
  end
  assign bank_open = open_r;

  // open row per bank, latched from all twelve lines
  always_ff @(posedge core_clk) begin
    if (cmd == SDC_ACT) row_r[bank_s] <= addr_s;
  end

  // ---------------------------------------------------------------
  // burst engine; a new column command overrides the running burst
  // ---------------------------------------------------------------
  logic col_cmd;
  assign col_cmd = (cmd == SDC_RD) || (cmd == SDC_WR);
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      burst_left_r <= '0;
      burst_bank_r <= '0;
      burst_ap_r   <= 1'b0;
      burst_wr_r   <= 1'b0;
      col_r        <= '0;
    end else if (col_cmd) begin
      burst_left_r <= 4'(BURST_LEN);
      burst_bank_r <= bank_s;
      burst_ap_r   <= addr_s[AP_BIT];
      burst_wr_r   <= (cmd == SDC_WR);
      col_r        <= addr_s[COL_W-1:0] + COL_W'(1);               // beat 0 uses addr_s directly
    end else if (cmd == SDC_BST) begin
      burst_left_r <= '0;
    end else if (burst_left_r != 4'd0 && cke_s) begin              // suspend holds burst
      burst_left_r <= burst_left_r - 4'd1;
      col_r        <= col_r + COL_W'(1);
    end
  end

  // ---------------------------------------------------------------
  // storage array
  // ---------------------------------------------------------------
  logic [MAW-1:0]    acc_addr;
  logic [1:0]        wr_be;
  logic [DATA_W-1:0] rd_word;
  assign acc_addr = col_cmd ? {bank_s, addr_s[COL_W-1:0]} : {burst_bank_r, col_r};
  // write lanes cut by mask in the same cycle
  assign wr_be = ((cmd == SDC_WR) || (burst_wr_r && burst_left_r > 4'd1 && !col_cmd)) && cke_s
                 ? ~mask_s : 2'b00;

  sdc_mem #(.AW(MAW)) u_mem (
    .core_clk   (core_clk),
    .wr_addr    (acc_addr),
    .wr_byte_en (wr_be),
    .wr_data    (dq_s),
    .rd_addr    (acc_addr),
    .rd_data    (rd_word)
  );

  // ---------------------------------------------------------------
  // read data path and byte-mask pipeline
  // ---------------------------------------------------------------
  logic       rd_act, rd_act_r;
  logic [1:0] mask_d1_r;
  assign rd_act = (cmd == SDC_RD) || (!burst_wr_r && burst_left_r > 4'd1 && !col_cmd);
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_act_r  <= 1'b0;
      mask_d1_r <= 2'b11;
    end else begin
      rd_act_r  <= rd_act;
      mask_d1_r <= mask_s;                                         // first of two latency stages
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      dq_out <= '0;
      dq_oe  <= 2'b00;
    end else begin
      dq_out <= rd_word;
      dq_oe  <= rd_act_r ? ~mask_d1_r : 2'b00;
    end
  end

  // ---------------------------------------------------------------
  // power state on gate low
  // ---------------------------------------------------------------
  logic [1:0] pwr_r;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pwr_r <= SDC_RUN;
    end else if (!cke_s) begin
      if (pwr_r == SDC_RUN) begin
        // refresh strobes on the edge the gate drops; live is always false here
        if (cke_prev_r && !cs_n_s && strb_s == SDC_REF)  pwr_r <= SDC_SELFREF;
        else if (burst_left_r != 4'd0)                   pwr_r <= SDC_SUSPEND;
        else                                             pwr_r <= SDC_PDOWN;
      end
    end else begin
      pwr_r <= SDC_RUN;
    end
  end
  assign power_state = pwr_r;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  sequence act_seen;
    cmd == SDC_ACT;
  endsequence

  bank_open_set_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    act_seen |=> open_r[$past(bank_s)]) else $error("activate did not open bank");
  row_latch_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    act_seen |=> row_r[$past(bank_s)] == $past(addr_s)) else $error("open row not latched");
  all_pre_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (cmd == SDC_PRE && addr_s[AP_BIT] && cmd != SDC_ACT) |=> open_r == '0) else $error("precharge all failed");
  deselect_ign_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    cs_n_s |-> cmd == SDC_NOP) else $error("deselected command decoded");
  mode_load_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    cmd == SDC_MRS |=> mode_r == $past(addr_s)) else $error("mode not loaded");
  strobe_dec_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (live && strb_s == 3'b101) |-> cmd == SDC_RD) else $error("read not decoded");
  read_mask_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (mask_s[0] && rd_act) |-> ##2 !dq_oe[0]) else $error("masked byte driven");
  write_mask_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    mask_s[1] |-> !wr_be[1]) else $error("masked byte written");
  gate_low_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (!cke_s) [*2] |-> pwr_r != SDC_RUN) else $error("no low power state");
endmodule

// file: tb/sdc_ctl_model.sv
/*
  sdc_ctl_model: controller side of the dram command pins.
  assumes a free running core_clk; pins change 1 ns after rising edges.
*/
`timescale 1ns/1ps
module sdc_ctl_model
  import sdc_pkg::*;
#(
  parameter int                PAUSE_CYC = 20,  // short stand-in for the power-up pause
  parameter int                MRS_GAP   = 2,
  parameter logic [ADDR_W-1:0] MODE_VAL  = 12'h023
) (
  // clock
  input  wire logic         core_clk,
  // command pins
  output logic              clock_gate_enable,
  output logic              chip_select_n,
  output logic              ras_n,
  output logic              cas_n,
  output logic              we_n,
  output logic [ADDR_W-1:0] addr,
  output logic              bank_select_lo,
  output logic              bank_select_hi,
  output logic              upper_byte_mask,
  output logic              lower_byte_mask,
  output logic [DATA_W-1:0] dq_in
);
  logic deselect = 1'b0;  // high sends the next command deselected

  // idle pins: nop, masks and gate high from power up
  initial begin
    {chip_select_n, ras_n, cas_n, we_n} = 4'hF;
    {clock_gate_enable, upper_byte_mask, lower_byte_mask} = 3'h7;
    addr = '0;
    {bank_select_hi, bank_select_lo} = 2'b00;
    dq_in = '0;
  end

  // one command, mask held one more cycle, then released
  task cmd(input sdc_cmd_t c, input logic [1:0] b, input logic [ADDR_W-1:0] a,
           input logic [DATA_W-1:0] d, input logic [1:0] m);
    @(posedge core_clk);
    #1;
    chip_select_n = deselect;
    {ras_n, cas_n, we_n} = c;
    addr = a;
    {bank_select_hi, bank_select_lo} = b;
    dq_in = d;
    {upper_byte_mask, lower_byte_mask} = m;
    @(posedge core_clk);
    #1;
    chip_select_n = 1'b1;
    {ras_n, cas_n, we_n} = SDC_NOP;
    addr = ~addr;    // released lines must not keep old values
    dq_in = ~dq_in;
    @(posedge core_clk);
    #1;
    {upper_byte_mask, lower_byte_mask} = 2'b00;
  endtask

  // power-up sequence; mode register not trusted before it
  task init_seq();
    repeat (PAUSE_CYC) @(posedge core_clk);
    cmd(SDC_PRE, 2'd0, 12'h400, 16'h0000, 2'b11);
    for (int i = 0; i < 8; i++) begin
      cmd(SDC_REF, 2'd0, 12'h000, 16'h0000, 2'b11);
    end
    cmd(SDC_MRS, 2'd0, MODE_VAL, 16'h0000, 2'b11);
    repeat (MRS_GAP) @(posedge core_clk);
    #1;
  endtask

  // clock gate change, off the sampling edge
  task gate(input logic en);
    @(posedge core_clk);
    #1;
    clock_gate_enable = en;
  endtask

  // refresh strobes on the edge the gate drops; the gate stays low after
  task self_ref();
    @(posedge core_clk);
    #1;
    clock_gate_enable = 1'b0;
    chip_select_n = 1'b0;
    {ras_n, cas_n, we_n} = SDC_REF;
    @(posedge core_clk);
    #1;
    chip_select_n = 1'b1;
    {ras_n, cas_n, we_n} = SDC_NOP;
  endtask
endmodule

// file: tb/sdram_command_init_activate_bench.sv
/*
  bench for sdc_core: row table, then hand-written awkward cases.
  assumes sdc_ctl_model drives the pins; three cycles per command keep bank timing.
*/
`timescale 1ns/1ps
module sdram_command_init_activate_bench
  import sdc_pkg::*;
;
  // bank and open row per case: the bench tracks what it has opened
  typedef struct packed {
    logic [1:0] bank; logic [11:0] row; logic [11:0] col; logic [15:0] data; logic [1:0] rmask;
  } sdc_row_t;
  sdc_row_t rows [4] = '{'{2'd0, 12'hFFF, 12'h000, 16'hA5C3, 2'b00}, '{2'd1, 12'h800, 12'h0FF, 16'h1234, 2'b01},
                         '{2'd2, 12'h001, 12'h07F, 16'hFFFF, 2'b10}, '{2'd3, 12'h555, 12'h000, 16'h0000, 2'b00}};
  logic core_clk, rst_n, cke, cs_n, ras_n, cas_n, we_n, bs_lo, bs_hi, um, lm;
  logic [11:0] addr;
  logic [15:0] dq_in, dq_out;
  logic [1:0]  dq_oe, power_state;
  logic [3:0]  bank_open;
  logic [11:0] mode_value;
  int n_errors = 0, checked = 0, cycles = 0;

  sdc_ctl_model i_ctl (.core_clk(core_clk), .clock_gate_enable(cke), .chip_select_n(cs_n), .ras_n(ras_n),
    .cas_n(cas_n), .we_n(we_n), .addr(addr), .bank_select_lo(bs_lo), .bank_select_hi(bs_hi),
    .upper_byte_mask(um), .lower_byte_mask(lm), .dq_in(dq_in));
  sdc_core #(.BURST_LEN(1)) i_dut (.core_clk(core_clk), .rst_n(rst_n), .clock_gate_enable(cke),
    .chip_select_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .addr(addr), .bank_select_lo(bs_lo),
    .bank_select_hi(bs_hi), .upper_byte_mask(um), .lower_byte_mask(lm), .dq_in(dq_in), .dq_out(dq_out),
    .dq_oe(dq_oe), .bank_open(bank_open), .mode_value(mode_value), .power_state(power_state));

  // ---------------------------------------------------------------
  // clock, timeout, shared tasks
  // ---------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // ceiling well above the few hundred cycles the tests need; far inside one refresh interval
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_errors++;
      close_out();
    end
  end
  task close_out();
    $display("checked %0d n_errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] want);
    checked++;
    if (seen !== want) begin
      n_errors++;
      $display("unexpected at %0t: seen %h want %h", $time, seen, want);
    end
  endtask
  // let the edge at which a synchronised command acts pass
  task tick();
    @(posedge core_clk);
    #1;
  endtask
  // read, then compare lane enables and only the driven lanes
  task rd_chk(input logic [1:0] b, input logic [11:0] col, input logic [15:0] exp, input logic [1:0] m);
    logic [15:0] ln;
    ln = {{8{~m[1]}}, {8{~m[0]}}};
    i_ctl.cmd(SDC_RD, b, col, 16'h0000, m);
    repeat (2) @(posedge core_clk);
    #1;
    chk(dq_oe, 2'(~m));
    chk(dq_out & ln, exp & ln);
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    rst_n = 1'b0;
    repeat (8) @(posedge core_clk);
    #1;
    chk({dq_oe, bank_open, power_state}, 0);
    chk({mode_value, dq_out}, 0);
    rst_n = 1'b1;
    i_ctl.init_seq();
    chk(mode_value, 12'h023);
    chk(bank_open, 4'h0);
    $display("test reset and init done");
    // activate then write each row, read all back after: shared columns expose bank mixups
    foreach (rows[i]) begin
      i_ctl.cmd(SDC_ACT, rows[i].bank, rows[i].row, 16'h0000, 2'b00);
      tick();
      chk(bank_open[rows[i].bank], 1'b1);
      i_ctl.cmd(SDC_WR, rows[i].bank, rows[i].col, rows[i].data, 2'b00);
    end
    foreach (rows[i]) rd_chk(rows[i].bank, rows[i].col, rows[i].data, rows[i].rmask);
    $display("test row table done");
    i_ctl.cmd(SDC_WR, 2'd0, 12'h000, 16'h5A5A, 2'b01);
    rd_chk(2'd0, 12'h000, 16'h5AC3, 2'b00);
    $display("test write mask done");
    i_ctl.deselect = 1'b1;
    i_ctl.cmd(SDC_PRE, 2'd0, 12'h400, 16'h0000, 2'b00);
    i_ctl.deselect = 1'b0;
    tick();
    chk(bank_open, 4'hF);
    i_ctl.cmd(SDC_PRE, 2'd1, 12'h000, 16'h0000, 2'b00);
    tick();
    chk(bank_open, 4'hD);
    i_ctl.cmd(SDC_PRE, 2'd0, 12'h400, 16'h0000, 2'b00);  // no bank left open
    tick();
    chk(bank_open, 4'h0);
    $display("test deselect and precharge done");
    i_ctl.cmd(SDC_ACT, 2'd2, 12'h001, 16'h0000, 2'b00);  // closed before re-activate
    tick();
    chk(bank_open, 4'h4);
    rd_chk(2'd2, 12'h47F, 16'hFFFF, 2'b00);
    repeat (4) @(posedge core_clk);
    #1;
    chk(bank_open, 4'h0);
    $display("test auto precharge done");
    i_ctl.gate(1'b0);
    repeat (6) @(posedge core_clk);
    #1;
    chk(power_state, SDC_PDOWN);
    i_ctl.gate(1'b1);
    repeat (6) @(posedge core_clk);
    #1;
    chk(power_state, SDC_RUN);
    // gate dropped on the beat after a read: the burst is held, so suspend
    i_ctl.cmd(SDC_ACT, 2'd0, 12'h000, 16'h0000, 2'b00);
    fork
      i_ctl.cmd(SDC_RD, 2'd0, 12'h000, 16'h0000, 2'b00);
      begin
        @(posedge core_clk);
        i_ctl.gate(1'b0);
      end
    join
    repeat (3) @(posedge core_clk);
    #1;
    chk(power_state, SDC_SUSPEND);
    i_ctl.gate(1'b1);
    i_ctl.cmd(SDC_PRE, 2'd0, 12'h400, 16'h0000, 2'b00);  // banks idle before self refresh
    tick();
    chk(power_state, SDC_RUN);
    i_ctl.self_ref();
    repeat (4) @(posedge core_clk);
    #1;
    chk(power_state, SDC_SELFREF);
    i_ctl.gate(1'b1);
    repeat (6) @(posedge core_clk);
    #1;
    chk(power_state, SDC_RUN);
    $display("test clock gate done");
    i_ctl.cmd(SDC_ACT, 2'd1, 12'h0AA, 16'h0000, 2'b00);
    rst_n = 1'b0;
    #1;
    chk({bank_open, mode_value}, 0);
    @(posedge core_clk);
    #1;
    rst_n = 1'b1;
    // first command right after release; the activate caught in reset is gone
    i_ctl.cmd(SDC_ACT, 2'd3, 12'h0AA, 16'h0000, 2'b00);
    tick();
    chk(bank_open, 4'h8);
    chk(mode_value, MODE_RST);
    $display("test mid-run reset done");
    close_out();
  end
endmodule
